//--- bridge_regs.svh
// constants of the management-link register bridge: window offsets, frame layout, patterns
// assumes inclusion by every bridge file; definitions only
// Notes on behaviour
// - link frames follow the clause 22 management format; host masters, device answers.
// - data pin sampled and changed only on rising edges of the host clock.
// - answer one of two phy addresses, picked by control bit or strap.
// - seven 16-bit window registers at management addresses 0 to 6.
// - registers 0 and 1 hold low and high halves of a word target address.
// - register 2 holds data low half; reads 0x8888 after an access error.
// - register 3 holds data high half; access launches; 0x8888 when busy or error.
// - register 4 acts as register 3, then bumps target address by one word.
// - register 5 reaches data high half without launching; 0x8888 after an error.
// - status bit0 busy, bit1 busy during last launch, bit2 access error.
// - host writes low half first; internal write starts after high-half write ends.
// - host reads low then high; data returned belongs to previous read.
// - slave pins take over their general-purpose pins when strap selects slave mode.
// - write of bus word starts a system-bus write at the pointer.
// - read of bus word returns contents, starts system-bus read, stores the result.
// - incrementing alias acts as bus word; pointer advances four after each start.
// - passive alias reads and overwrites bus word, never starts a bus access.
// - system-bus error sets error flag and loads the fixed error pattern.
// - while bus busy, reads of the three word aliases return 0x88888888.
// - incrementing reads advance the pointer only when not answered while busy.
`ifndef BRIDGE_REGS_SVH
`define BRIDGE_REGS_SVH
// management window addresses
`define WIN_ADDR_LO 5'h00
`define WIN_ADDR_HI 5'h01
`define WIN_DATA_LO 5'h02
`define WIN_DATA_GO 5'h03
`define WIN_DATA_GO_INC 5'h04
`define WIN_DATA_PASSIVE 5'h05
`define WIN_STATUS 5'h06
// status bit positions
`define STAT_BUSY 0
`define STAT_BUSY_RD 1
`define STAT_ERR 2
// bus access block: word addresses on the internal register space
`define LOC_BASE 32'h0000_7c00
`define LOC_CTRL 3'h0
`define LOC_PTR 3'h1
`define LOC_WORD 3'h2
`define LOC_INCR 3'h3
`define LOC_PASS 3'h4
`define CTRL_BUSY 0
`define CTRL_ERR 1
// patterns and steps
`define HALF_ERR_PAT 16'h8888
`define WORD_BUSY_PAT 32'h8888_8888
`define SB_ERR_PAT 36'h8_8888_8888
`define PTR_STEP 32'h0000_0004
`define ADDR_STEP 32'h0000_0001
// frame layout
`define PRE_LEN 6'h20
`define HDR_LAST 5'h0c
`define DATA_BITS 5'h10
`define DATA_LAST 5'h0f
`define ST_SECOND 1'b1
`define OP_RD 2'b10
`define OP_WR 2'b01
`define PHY_ADDR_A 5'h00
`define PHY_ADDR_B 5'h01
`endif

//--- bridge_pkg.sv
// types of the management-link register bridge
// assumes bridge_regs.svh supplies the numbers
package bridge_pkg;
   typedef enum logic [2:0] {L_IDLE = 3'b000, L_HDR = 3'b001, L_TA = 3'b010, L_RD = 3'b011,
                             L_WD = 3'b100} link_fsm_t;
   typedef enum logic [0:0] {C_IDLE = 1'b0, C_WAIT = 1'b1} core_fsm_t;
   // request toward a bus, held until answered
   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_req_t;
   // one-cycle answer of a bus
   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } bus_rsp_t;
   // link-clock state
   typedef struct packed {
      link_fsm_t lst;
      logic [4:0] cnt;
      logic [5:0] pre_cnt;
      logic [15:0] sr;
      logic [15:0] tx;
      logic rd;
      logic [4:0] reg_sel;
      logic [15:0] addr_lo;
      logic [15:0] addr_hi;
      logic [15:0] dat_lo;
      logic [15:0] dat_hi;
      logic busy;
      logic busy_rd;
      logic err;
      logic incr;
      logic op_we;
      logic launch_tgl;
      logic dn1, dn2, dn3;
      logic [2:0] sy1, sy2;
      logic io_out;
      logic io_oe;
   } link_state_t;
   // core-clock state
   typedef struct packed {
      core_fsm_t cst;
      logic ln1, ln2, ln3;
      logic done_tgl;
      logic [31:0] res_data;
      logic res_err;
      bus_req_t csr;
      bus_req_t sb;
      logic ba_busy;
      logic ba_err;
      logic [31:0] ba_ptr;
      logic [31:0] ba_word;
      logic ms1, ms2;
   } core_state_t;
endpackage : bridge_pkg

//--- mgmt_indirect_register_bridge.sv
// management-link slave bridging 16-bit window registers onto 32-bit internal registers,
// plus the shared system bus access block living in the internal register space
// assumes a host-made link clock that may stop between frames, and one-cycle bus answers
`timescale 1ns/1ns
`default_nettype none
`include "bridge_regs.svh"
module mgmt_indirect_register_bridge #(
   parameter logic [4:0] PHY_ADDR_0 = `PHY_ADDR_A,
   parameter logic [4:0] PHY_ADDR_1 = `PHY_ADDR_B
) (
   // core clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // management link pins
   input wire logic mgmt_slave_clock_pin,
   input wire logic mgmt_slave_io_pin_in,
   output logic mgmt_slave_io_pin_out,
   output logic mgmt_slave_io_pin_oe,
   // straps and control bit
   input wire logic slave_mode_strap,
   input wire logic addr_sel_strap,
   input wire logic phy_address_select,
   output logic gpio_takeover,
   // internal register bus master
   output var bridge_pkg::bus_req_t csr_cmd,
   input wire bridge_pkg::bus_rsp_t csr_rsp,
   // shared system bus master
   output var bridge_pkg::bus_req_t sb_cmd,
   input wire bridge_pkg::bus_rsp_t sb_rsp
);
   localparam logic [35:0] ERR_PAT36 = `SB_ERR_PAT;

   bridge_pkg::link_state_t lq, ln;
   bridge_pkg::core_state_t cq, cn;

   logic try_launch;
   logic try_incr;
   logic try_we;

   logic ptr_step;

   logic [31:0] la;
   logic [31:0] lw;

   // read view of the window; error and busy patterns mask stale halves
   function automatic logic [15:0] rd_value(input logic [4:0] ra, input bridge_pkg::link_state_t s);
      logic [15:0] v;
      v = 16'h0000;
      case (ra)
         `WIN_ADDR_LO: v = s.addr_lo;
         `WIN_ADDR_HI: v = s.addr_hi;
         `WIN_DATA_LO: v = s.err ? `HALF_ERR_PAT : s.dat_lo;
         `WIN_DATA_GO, `WIN_DATA_GO_INC: v = (s.busy || s.err) ? `HALF_ERR_PAT : s.dat_hi;
         `WIN_DATA_PASSIVE: v = s.err ? `HALF_ERR_PAT : s.dat_hi;
         `WIN_STATUS: begin
            v[`STAT_BUSY] = s.busy;
            v[`STAT_BUSY_RD] = s.busy_rd;
            v[`STAT_ERR] = s.err;
         end
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : rd_value

   // link side: frame decode, window registers, launch and completion
   always_comb begin
      ln = lq;
      try_launch = 1'b0;
      try_incr = 1'b0;
      try_we = 1'b0;

      ln.sy1 = {slave_mode_strap, addr_sel_strap, phy_address_select};
      ln.sy2 = lq.sy1;
      ln.dn1 = cq.done_tgl;
      ln.dn2 = lq.dn1;
      ln.dn3 = lq.dn2;

      // completion from the core side; result words are stable once the toggle is seen
      if (lq.dn2 != lq.dn3) begin
         ln.busy = 1'b0;
         ln.err = cq.res_err;
         if (!lq.op_we && !cq.res_err) begin
            ln.dat_lo = cq.res_data[15:0];
            ln.dat_hi = cq.res_data[31:16];
         end
         if (lq.incr) begin
            {ln.addr_hi, ln.addr_lo} = {lq.addr_hi, lq.addr_lo} + `ADDR_STEP;
         end
      end

      // frame walk, a bit per clock rise
      case (lq.lst)
         bridge_pkg::L_IDLE: begin
            ln.io_oe = 1'b0;
            if (mgmt_slave_io_pin_in) begin
               if (lq.pre_cnt != `PRE_LEN) begin
                  ln.pre_cnt = lq.pre_cnt + 6'h01;
               end
            end else begin
               ln.pre_cnt = 6'h00;
               // start bit only counts after a full preamble and in slave mode
               if (lq.pre_cnt == `PRE_LEN && lq.sy2[2]) begin
                  ln.lst = bridge_pkg::L_HDR;
                  ln.cnt = 5'h00;
               end
            end
         end
         // start, opcode, phy, register
         bridge_pkg::L_HDR: begin
            ln.sr = {lq.sr[14:0], mgmt_slave_io_pin_in};
            ln.cnt = lq.cnt + 5'h01;
            if (lq.cnt == `HDR_LAST) begin
               ln.lst = bridge_pkg::L_IDLE;
               ln.cnt = 5'h00;
               if (ln.sr[12] == `ST_SECOND && (ln.sr[11:10] == `OP_RD || ln.sr[11:10] == `OP_WR) &&
                   ln.sr[9:5] == ((lq.sy2[0] || lq.sy2[1]) ? PHY_ADDR_1 : PHY_ADDR_0)) begin
                  ln.lst = bridge_pkg::L_TA;
                  ln.rd = (ln.sr[11:10] == `OP_RD);
                  ln.reg_sel = ln.sr[4:0]; // sr moves on with the data
                  if (ln.sr[11:10] == `OP_RD) begin
                     // value is taken before the launch, so it belongs to the previous read
                     ln.tx = rd_value(ln.sr[4:0], ln);
                     if (ln.sr[4:0] == `WIN_DATA_GO || ln.sr[4:0] == `WIN_DATA_GO_INC) begin
                        try_launch = 1'b1;
                        try_incr = (ln.sr[4:0] == `WIN_DATA_GO_INC);
                     end
                  end
               end
            end
         end
         // turnaround
         bridge_pkg::L_TA: begin
            if (lq.rd) begin
               // host released the pin during the first turnaround bit
               ln.io_out = 1'b0;
               ln.io_oe = 1'b1;
               ln.lst = bridge_pkg::L_RD;
               ln.cnt = 5'h00;
            end else if (lq.cnt == 5'h00) begin
               ln.cnt = 5'h01;
            end else begin
               ln.lst = bridge_pkg::L_WD;
               ln.cnt = 5'h00;
            end
         end
         // read data out, msb first
         bridge_pkg::L_RD: begin
            if (lq.cnt == `DATA_BITS) begin
               ln.io_oe = 1'b0;
               ln.lst = bridge_pkg::L_IDLE;
            end else begin
               ln.io_out = lq.tx[15];
               ln.tx = {lq.tx[14:0], 1'b0};
               ln.cnt = lq.cnt + 5'h01;
            end
         end
         // write data in
         bridge_pkg::L_WD: begin
            ln.sr = {lq.sr[14:0], mgmt_slave_io_pin_in};
            ln.cnt = lq.cnt + 5'h01;
            if (lq.cnt == `DATA_LAST) begin
               ln.lst = bridge_pkg::L_IDLE;
               ln.pre_cnt = 6'h00;
               case (lq.reg_sel)
                  `WIN_ADDR_LO: ln.addr_lo = ln.sr;
                  `WIN_ADDR_HI: ln.addr_hi = ln.sr;
                  `WIN_DATA_LO: ln.dat_lo = ln.sr;
                  `WIN_DATA_GO, `WIN_DATA_GO_INC: begin
                     ln.dat_hi = ln.sr;
                     try_launch = 1'b1;
                     try_we = 1'b1;
                     try_incr = (lq.reg_sel == `WIN_DATA_GO_INC);
                  end
                  `WIN_DATA_PASSIVE: ln.dat_hi = ln.sr;
                  default: ln.pre_cnt = 6'h00;
               endcase
            end
         end
         default: ln.lst = bridge_pkg::L_IDLE;
      endcase

      // a launch while busy only leaves a mark; the running access is untouched
      if (try_launch) begin
         if (ln.busy) begin
            ln.busy_rd = 1'b1;
         end else begin
            ln.busy = 1'b1;
            ln.busy_rd = 1'b0;
            ln.err = 1'b0;
            ln.incr = try_incr;
            ln.op_we = try_we;
            ln.launch_tgl = ~lq.launch_tgl;
         end
      end
   end

   always_ff @(posedge mgmt_slave_clock_pin or negedge rstn) begin
      if (!rstn) begin
         lq <= '0;
      end else begin
         lq <= ln;
      end
   end

   // payload words seen by the core; held still by the handshake until done returns
   assign la = {lq.addr_hi, lq.addr_lo};
   assign lw = {lq.dat_hi, lq.dat_lo};

   // core side: internal access engine and the system bus access block
   always_comb begin
      cn = cq;
      ptr_step = 1'b0;

      cn.ln1 = lq.launch_tgl;
      cn.ln2 = cq.ln1;
      cn.ln3 = cq.ln2;
      cn.ms1 = slave_mode_strap;
      cn.ms2 = cq.ms1;

      // system bus completion
      if (cq.sb.req && (sb_rsp.ack || sb_rsp.err)) begin
         cn.sb.req = 1'b0;
         cn.ba_busy = 1'b0;
         if (sb_rsp.err) begin
            cn.ba_err = 1'b1;
            cn.ba_word = ERR_PAT36[31:0];
         end else if (!cq.sb.we) begin
            cn.ba_word = sb_rsp.rdata;
         end
      end

      // local slots answer at once
      case (cq.cst)
         // wait for a fresh launch
         bridge_pkg::C_IDLE: begin
            if (cq.ln2 != cq.ln3) begin
               if (la[31:3] == `LOC_BASE >> 3) begin
                  cn.res_err = 1'b0;
                  cn.res_data = 32'h0000_0000;
                  case (la[2:0])
                     `LOC_CTRL: begin
                        cn.res_data[`CTRL_BUSY] = cn.ba_busy;
                        cn.res_data[`CTRL_ERR] = cn.ba_err;
                     end
                     `LOC_PTR: begin
                        if (lq.op_we) begin
                           cn.ba_ptr = lw;
                        end else begin
                           cn.res_data = cn.ba_ptr;
                        end
                     end
                     `LOC_WORD, `LOC_INCR: begin
                        if (!lq.op_we) begin
                           cn.res_data = cn.ba_busy ? `WORD_BUSY_PAT : cn.ba_word;
                        end
                        // a busy engine ignores new starts so the pointer stays put
                        if (!cn.ba_busy) begin
                           if (lq.op_we) begin
                              cn.ba_word = lw;
                           end
                           cn.sb.req = 1'b1;
                           cn.sb.we = lq.op_we;
                           cn.sb.addr = cn.ba_ptr;
                           cn.sb.wdata = lw;
                           cn.ba_busy = 1'b1;
                           cn.ba_err = 1'b0;
                           if (la[2:0] == `LOC_INCR) begin
                              cn.ba_ptr = cn.ba_ptr + `PTR_STEP;
                              ptr_step = 1'b1;
                           end
                        end
                     end
                     `LOC_PASS: begin
                        if (lq.op_we) begin
                           cn.ba_word = lw;
                        end else begin
                           cn.res_data = cn.ba_busy ? `WORD_BUSY_PAT : cn.ba_word;
                        end
                     end
                     default: cn.res_err = 1'b1;
                  endcase
                  cn.done_tgl = ~cq.done_tgl;
               end else begin
                  cn.csr.req = 1'b1;
                  cn.csr.we = lq.op_we;
                  cn.csr.addr = la;
                  cn.csr.wdata = lw;
                  cn.cst = bridge_pkg::C_WAIT;
               end
            end
         end
         // hold request until answered
         bridge_pkg::C_WAIT: begin
            if (csr_rsp.ack || csr_rsp.err) begin
               cn.csr.req = 1'b0;
               cn.res_err = csr_rsp.err;
               cn.res_data = csr_rsp.rdata;
               cn.done_tgl = ~cq.done_tgl;
               cn.cst = bridge_pkg::C_IDLE;
            end
         end
         default: cn.cst = bridge_pkg::C_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cq <= '0;
      end else begin
         cq <= cn;
      end
   end

   // outputs straight from state flops
   assign mgmt_slave_io_pin_out = lq.io_out;
   assign mgmt_slave_io_pin_oe = lq.io_oe;
   assign gpio_takeover = cq.ms2;
   assign csr_cmd = cq.csr;
   assign sb_cmd = cq.sb;

   // link-side checks
   sequence s_read_hdr;
      lq.lst == bridge_pkg::L_TA && lq.rd;
   endsequence
   sequence s_turn_drive;
      lq.io_oe && !lq.io_out ##1 lq.io_oe [*8];
   endsequence

   a_read_turn_drive: assert property (@(posedge mgmt_slave_clock_pin) disable iff (!rstn)
      s_read_hdr |=> s_turn_drive) else $error("read turnaround not driven low then held");

   a_oe_only_read: assert property (@(posedge mgmt_slave_clock_pin) disable iff (!rstn)
      lq.io_oe |-> lq.lst == bridge_pkg::L_RD) else $error("pin driven outside read data");

   a_launch_sets_busy: assert property (@(posedge mgmt_slave_clock_pin) disable iff (!rstn)
      (try_launch && (!lq.busy || lq.dn2 != lq.dn3)) |=>
      lq.busy && !lq.busy_rd && lq.launch_tgl != $past(lq.launch_tgl))
      else $error("launch did not set busy");

   a_busy_launch_held: assert property (@(posedge mgmt_slave_clock_pin) disable iff (!rstn)
      (try_launch && lq.busy && lq.dn2 == lq.dn3) |=> lq.busy_rd && $stable(lq.launch_tgl))
      else $error("busy launch disturbed access");

   a_incr_after_done: assert property (@(posedge mgmt_slave_clock_pin) disable iff (!rstn)
      (lq.dn2 != lq.dn3 && lq.incr && lq.lst != bridge_pkg::L_WD) |=>
      la == $past(la) + `ADDR_STEP)
      else $error("target address not advanced by one word");


   // core-side checks
   a_sb_busy_req: assert property (@(posedge core_clk) disable iff (!rstn)
      cq.sb.req |-> cq.ba_busy) else $error("bus request without busy");

   a_sb_err_pattern: assert property (@(posedge core_clk) disable iff (!rstn)
      (cq.sb.req && sb_rsp.err) |=> cq.ba_err && !cq.ba_busy && cq.ba_word == ERR_PAT36[31:0])
      else $error("bus error not reported");

   a_ptr_step_four: assert property (@(posedge core_clk) disable iff (!rstn)
      ptr_step |=> cq.ba_ptr == $past(cq.ba_ptr) + `PTR_STEP && cq.sb.req)
      else $error("pointer not advanced by four");

   a_csr_req_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      (cq.csr.req && !csr_rsp.ack && !csr_rsp.err) |=> cq.csr.req && $stable(cq.csr.addr))
      else $error("internal request dropped before answer");

   // local bus block slot decoded this cycle
   sequence s_local_hit;
      cq.cst == bridge_pkg::C_IDLE && cq.ln2 != cq.ln3 && la[31:3] == `LOC_BASE >> 3;
   endsequence
   a_busy_word_read: assert property (@(posedge core_clk) disable iff (!rstn)
      s_local_hit ##0 (!lq.op_we && la[2:0] >= `LOC_WORD && la[2:0] <= `LOC_PASS && cq.ba_busy && !sb_rsp.ack &&
      !sb_rsp.err) |=> cq.res_data == `WORD_BUSY_PAT) else $error("busy word read not patterned");
   a_passive_no_start: assert property (@(posedge core_clk) disable iff (!rstn)
      s_local_hit ##0 (la[2:0] == `LOC_PASS && !cq.sb.req) |=> !cq.sb.req) else $error("passive access started bus");
endmodule : mgmt_indirect_register_bridge
`default_nettype wire

//--- mgmt_host_model.sv
// management-frame master standing in for the external host cpu
// assumes the bench resolves the data wire with a pull-up and feeds the level back
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model (
   // link clock and host data drive
   output var logic mgmt_slave_clock_pin,
   output var logic host_io_out,
   output var logic host_io_oe,
   // resolved wire level
   input wire logic io_wire
);
   initial begin
      mgmt_slave_clock_pin = 1'b0;
      host_io_out = 1'b0;
      host_io_oe = 1'b0;
   end

   // one 6 ns link period; the clock stands low between frames
   task automatic tick();
      #3 mgmt_slave_clock_pin = 1'b1;
      #3 mgmt_slave_clock_pin = 1'b0;
   endtask : tick

   // whole frame, fresh preamble each time, msb first; data changes only after the falling edge
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic [63:0] bits;
      int last;
      bits = {32'hffff_ffff, 2'b01, op, phy, rg, 2'b10, wd};
      last = (op == 2'b10) ? 18 : 0;
      rd = 16'h0000;
      for (int i = 63; i >= last; i--) begin
         host_io_oe = 1'b1;
         host_io_out = bits[i];
         tick();
      end
      // release before the turnaround of a read, after the data of a write; a read then clocks out 18 more periods
      host_io_oe = 1'b0;
      if (op == 2'b10) begin
         for (int i = 0; i < 18; i++) begin
            tick();
            if (i >= 1 && i <= 16) begin
               rd = {rd[14:0], io_wire};
            end
         end
      end
      #3; // no re-drive in one step
   endtask : frame
endmodule : mgmt_host_model
`default_nettype wire

//--- mgmt_indirect_register_bridge_test.sv
// self-checking bench of the management-link bridge with csr and system bus responders
// assumes the host model clocks the link only inside frames; the data wire has a pull-up
`timescale 1ns/1ns
`default_nettype none
module mgmt_indirect_register_bridge_test;
   localparam logic [31:0] ERR_A = 32'h0012_3400;
   localparam logic [31:0] SB_ERR = 32'h0bad_0000;
   localparam logic [31:0] B = 32'h0000_7c00;
   int fail_count = 0, n_compared = 0, csr_n = 0, sb_n = 0, csr_dly = 2, sb_dly = 0, csr_reqs = 0, sb_reqs = 0, k;
   logic core_clk = 1'b0, rstn = 1'b1, slave_mode_strap = 1'b1, addr_sel_strap = 1'b0, phy_address_select = 1'b0;
   logic mgmt_slave_clock_pin, io_wire, dut_out, dut_oe, host_out, host_oe, gpio_takeover;
   bridge_pkg::bus_req_t csr_cmd, sb_cmd, csr_last, sb_last;
   bridge_pkg::bus_rsp_t csr_rsp = '0, sb_rsp = '0;
   logic [31:0] mem [logic [31:0]];
   logic [4:0] phy = 5'h00;
   logic [15:0] h, lv;
   logic [31:0] w, a, d, p;

   // resolved data wire, pulled up when nobody drives
   assign io_wire = dut_oe ? dut_out : (host_oe ? host_out : 1'b1);
   always #10 core_clk = ~core_clk;

   mgmt_indirect_register_bridge u_dut (.core_clk(core_clk), .rstn(rstn), .mgmt_slave_clock_pin(mgmt_slave_clock_pin),
      .mgmt_slave_io_pin_in(io_wire), .mgmt_slave_io_pin_out(dut_out), .mgmt_slave_io_pin_oe(dut_oe),
      .slave_mode_strap(slave_mode_strap), .addr_sel_strap(addr_sel_strap), .phy_address_select(phy_address_select),
      .gpio_takeover(gpio_takeover), .csr_cmd(csr_cmd), .csr_rsp(csr_rsp), .sb_cmd(sb_cmd), .sb_rsp(sb_rsp));
   mgmt_host_model u_host (.mgmt_slave_clock_pin(mgmt_slave_clock_pin), .host_io_out(host_out),
      .host_io_oe(host_oe), .io_wire(io_wire));

   // unwritten places read as the inverted address so stale data shows
   function automatic logic [31:0] mem_rd(input logic [31:0] ad);
      return mem.exists(ad) ? mem[ad] : ~ad;
   endfunction : mem_rd
   function automatic logic [31:0] word_addr(input logic [31:0] raw);
      return (raw & 32'h00ff_ffff) >> 2;
   endfunction : word_addr

   // csr responder: answers after csr_dly cycles, errors at one address
   always @(posedge core_clk) begin
      #1;
      csr_rsp = '0;
      if (csr_cmd.req && csr_n++ >= csr_dly) begin
         csr_n = 0;
         csr_reqs++;
         csr_last = csr_cmd;
         csr_rsp = '{ack: csr_cmd.addr != ERR_A, err: csr_cmd.addr == ERR_A, rdata: mem_rd(csr_cmd.addr)};
         if (csr_cmd.we) mem[csr_cmd.addr] = csr_cmd.wdata;
      end
   end
   // system bus responder, same shape with its own delay
   always @(posedge core_clk) begin
      #1;
      sb_rsp = '0;
      if (sb_cmd.req && sb_n++ >= sb_dly) begin
         sb_n = 0;
         sb_reqs++;
         sb_last = sb_cmd;
         sb_rsp = '{ack: sb_cmd.addr != SB_ERR, err: sb_cmd.addr == SB_ERR, rdata: mem_rd(sb_cmd.addr)};
         if (sb_cmd.we) mem[sb_cmd.addr] = sb_cmd.wdata;
      end
   end

   task automatic chk_half(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk_half
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk_word
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic wr(input logic [4:0] r, input logic [15:0] v);
      u_host.frame(2'b01, phy, r, v, h);
   endtask : wr
   task automatic rd(input logic [4:0] r, output logic [15:0] v);
      u_host.frame(2'b10, phy, r, 16'h0000, v);
   endtask : rd
   // bounded poll of window busy, or of the bus block busy flag when sb is set
   task automatic idle(input bit sb);
      logic [31:0] s;
      for (int i = 0; i < 40; i++) begin
         if (sb) begin
            rd32(B, s);
         end else begin
            rd(5'h06, s[15:0]);
         end
         if (s[0] === 1'b0) return;
      end
      fail_count++;
      $display("unexpected busy flag: expected 0 seen 1");
      close_out();
   endtask : idle
   task automatic set_a(input logic [31:0] ad);
      wr(5'h00, ad[15:0]);
      wr(5'h01, ad[31:16]);
   endtask : set_a
   task automatic wr32(input logic [31:0] ad, input logic [31:0] v);
      set_a(ad);
      wr(5'h02, v[15:0]);
      wr(5'h03, v[31:16]);
      idle(0);
   endtask : wr32
   task automatic rd32(input logic [31:0] ad, output logic [31:0] v);
      set_a(ad);
      rd(5'h03, lv);
      idle(0);
      rd(5'h02, v[15:0]);
      rd(5'h05, v[31:16]);
   endtask : rd32

   initial begin
      k = $urandom(41);
      #1 rstn = 1'b0; // edge clears the idle link side
      repeat (3) @(posedge core_clk);
      #1;
      chk_half("reset outputs", 16'h0000, {12'h000, gpio_takeover, csr_cmd.req, sb_cmd.req, dut_oe});
      @(posedge core_clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk_half("pin takeover", 16'h0001, {15'h0000, gpio_takeover});
      $display("test reset done");
      // random word writes and reads through the window
      for (int i = 0; i < 4; i++) begin
         a = word_addr($urandom) | 32'h0010_0000;
         d = $urandom;
         wr32(a, d);
         chk_word("csr write address", a, csr_last.addr);
         chk_word("csr write data", d, csr_last.wdata);
         rd32(a, w);
         chk_half("launch read value", d[31:16], lv);
         chk_word("window read data", d, w);
      end
      set_a(a);
      rd(5'h04, h);
      idle(0);
      rd(5'h03, h);
      idle(0);
      chk_word("incremented target", a + 32'h1, csr_last.addr);
      $display("test window done");
      phy = 5'h01;
      rd(5'h06, h);
      chk_half("status at unselected phy", 16'hffff, h);
      @(posedge core_clk);
      #1 phy_address_select = 1'b1;
      rd(5'h06, h);
      chk_half("status at selected phy", 16'h0000, h);
      // slow csr answer so the second launch lands while busy
      csr_dly = 100;
      k = csr_reqs;
      set_a(a);
      rd(5'h03, h);
      rd(5'h03, h);
      chk_half("busy launch value", 16'h8888, h);
      rd(5'h06, h);
      chk_half("busy status", 16'h0003, h);
      idle(0);
      chk_word("csr requests", k + 1, csr_reqs);
      csr_dly = 2;
      rd32(ERR_A, w);
      chk_word("error read data", 32'h8888_8888, w);
      rd(5'h06, h);
      chk_half("error status", 16'h0004, h);
      $display("test busy and error done");
      // bus access block behind the window
      p = $urandom & 32'h0fff_fffc;
      d = $urandom;
      wr32(B + 1, p);
      wr32(B + 2, d);
      chk_word("bus write address", p, sb_last.addr);
      chk_word("bus write data", d, sb_last.wdata);
      wr32(B + 3, ~d);
      chk_word("bus incr write address", p, sb_last.addr);
      rd32(B + 1, w);
      chk_word("pointer after incr", p + 32'h4, w);
      k = sb_reqs;
      wr32(B + 4, d ^ 32'h00ff_00ff);
      rd32(B + 4, w);
      chk_word("passive word", d ^ 32'h00ff_00ff, w);
      chk_word("bus requests", k, sb_reqs);
      rd32(B + 2, w);
      chk_word("word before read", d ^ 32'h00ff_00ff, w);
      rd32(B + 4, w);
      chk_word("word after read", mem_rd(p + 32'h4), w);
      $display("test bus window done");
      sb_dly = 600;
      rd32(B + 3, w);
      rd32(B, w);
      chk_word("bus busy", 32'h0000_0001, w);
      rd32(B + 3, w);
      chk_word("busy word", 32'h8888_8888, w);
      idle(1);
      rd32(B + 4, w);
      chk_word("passive after busy", mem_rd(p + 32'h4), w);
      rd32(B + 1, w);
      chk_word("pointer after busy read", p + 32'h8, w);
      sb_dly = 0;
      wr32(B + 1, SB_ERR);
      rd32(B + 2, w);
      rd32(B, w);
      chk_word("bus error flag", 32'h0000_0002, w);
      rd32(B + 4, w);
      chk_word("bus error word", 32'h8888_8888, w);
      $display("test bus busy and error done");
      close_out();
   end
endmodule : mgmt_indirect_register_bridge_test
`default_nettype wire
